// [smx_map.vh]
// constants for the bus front end of the eight-line expander
`ifndef SMX_MAP_VH
`define SMX_MAP_VH
// ---------------------------------------------------------------
// command codes (register pointer values)
// ---------------------------------------------------------------
`define SMX_CMD_NOUT   8'h00
`define SMX_CMD_NRISE  8'h01
`define SMX_CMD_NFALL  8'h02
`define SMX_CMD_SOUT   8'h03
`define SMX_CMD_SRISE  8'h04
`define SMX_CMD_SFALL  8'h05
`define SMX_CMD_RDBK   8'h06
`define SMX_CMD_AUX    8'h07
`define SMX_CMD_SAMPLE 8'h08
`define SMX_CMD_SRST   8'h09
`define SMX_NUM_REGS   10
// ---------------------------------------------------------------
// addresses and reset values
// ---------------------------------------------------------------
`define SMX_ALERT_ADDR 7'h19
`define SMX_ADDR_BASE0 4'h2
`define SMX_ADDR_BASE1 4'hC
`define SMX_ADDR_BASE2 4'h7
`define SMX_LVL_LOW    2'h0
`define SMX_LVL_FLOAT  2'h1
`define SMX_LVL_HIGH   2'h2
`define SMX_OUT_RST    8'h00
`define SMX_MASK_RST   8'hFF
`define SMX_PTR_RST    8'h00
`endif

// [smx_regfile.v]
// six-entry register store with registered read data
module smx_regfile (
   // clock and reset
   input  wire       sys_clk,
   input  wire       srst,
   // write port
   input  wire       wr_en,
   input  wire [3:0] wr_idx,
   input  wire [7:0] wr_data,
   // read port
   input  wire [3:0] rd_idx,
   input  wire [7:0] pin_state,
   input  wire [7:0] aux_state,
   output reg  [7:0] rd_data,
   // set outputs
   output wire [7:0] n_out,
   output wire [7:0] n_rise,
   output wire [7:0] n_fall,
   output wire [7:0] s_out,
   output wire [7:0] s_rise,
   output wire [7:0] s_fall
);
`include "smx_map.vh"
   reg [7:0] mem_q [0:5];
   genvar i;
   // ---------------------------------------------------------------
   // writable data registers
   // ---------------------------------------------------------------
   generate
      for (i = 0; i < 6; i = i + 1) begin : g_reg
         // masks power up set so all interrupts stay masked
         always @(posedge sys_clk) begin
            if (srst)
               mem_q[i] <= (i % 3 == 0) ? `SMX_OUT_RST : `SMX_MASK_RST;
            else if (wr_en && wr_idx == i)
               mem_q[i] <= wr_data;
         end
      end
   endgenerate
   assign n_out  = mem_q[0];
   assign n_rise = mem_q[1];
   assign n_fall = mem_q[2];
   assign s_out  = mem_q[3];
   assign s_rise = mem_q[4];
   assign s_fall = mem_q[5];
   // registered read; readback and status are read only
   always @(posedge sys_clk) begin
      if (srst)
         rd_data <= 8'h00;
      else if (rd_idx < 4'h6)
         rd_data <= mem_q[rd_idx[2:0]];
      else if (rd_idx == 4'h6)
         rd_data <= pin_state;
      else if (rd_idx == 4'h7)
         rd_data <= aux_state;
      else
         rd_data <= 8'h00;
   end
endmodule

// [smx_slave.v]
// bus slave front end of the eight-line open-drain expander
// How it works
// - data falling while clock high is start
// - data rising while clock high is stop
// - data changes only while clock low
// - eight-bit bytes sampled on clock rise
// - ninth clock carries the receiver acknowledge
// - address built from two three-level selects
// - matching address acknowledged by pulling data
// - answer own address and 0x19 only
// - address latched at reset, sample, soft reset
// - write expects command and optional data
// - start or stop mid-byte discards everything
// - register written after data ack falls
// - read returns register the pointer selects
// - command byte stored as register pointer
// - six data registers are read/write
// - readback and status registers read only
// - sample and soft reset are send-byte
// - receive-byte returns previously pointed register
// - pointer clears to zero at reset
// - soft reset leaves pointer alone
// - suspend low selects suspend set, after a two-flop synchroniser
// - writes to read-only go to output
// - all masks set at power-up
module smx_slave (
   // clock and reset
   input  wire       sys_clk,
   input  wire       srst,
   // bus pins
   input  wire       bus_clk_in,
   input  wire       bus_data_in,
   output wire       bus_data_out,
   output wire       bus_data_oe,
   // address select straps, 2'h0 low, 2'h1 float, 2'h2 high
   input  wire [1:0] addr_sel_lo_pin,
   input  wire [1:0] addr_sel_hi_pin,
   // suspend and I/O lines
   input  wire       suspend_select_in,
   input  wire [7:0] open_drain_lines_in,
   input  wire [7:0] aux_status_in,
   output wire [7:0] open_drain_lines_out,
   output wire [7:0] open_drain_lines_oe,
   output wire [7:0] rise_mask,
   output wire [7:0] fall_mask
);
`include "smx_map.vh"
   // ---------------------------------------------------------------
   // state codes, one-hot
   // ---------------------------------------------------------------
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_RX   = 5'h02;
   localparam [4:0] ST_ACK  = 5'h04;
   localparam [4:0] ST_TX   = 5'h08;
   localparam [4:0] ST_MACK = 5'h10;
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   reg [1:0] scl_s_q;
   reg [1:0] sda_s_q;
   reg [1:0] sus_s_q;
   reg       scl_q;
   reg       sda_q;
   reg [7:0] lines_m_q;
   reg [7:0] lines_s_q;
   // two flops on every foreign input but aux_status_in before use
   always @(posedge sys_clk) begin
      if (srst) begin
         scl_s_q   <= 2'h3;
         sda_s_q   <= 2'h3;
         sus_s_q   <= 2'h3;
         scl_q     <= 1'b1;
         sda_q     <= 1'b1;
         lines_m_q <= 8'h00;
         lines_s_q <= 8'h00;
      end else begin
         scl_s_q   <= {scl_s_q[0], bus_clk_in};
         sda_s_q   <= {sda_s_q[0], bus_data_in};
         sus_s_q   <= {sus_s_q[0], suspend_select_in};
         scl_q     <= scl_s_q[1];
         sda_q     <= sda_s_q[1];
         lines_m_q <= open_drain_lines_in;
         lines_s_q <= lines_m_q;
      end
   end
   wire scl      = scl_s_q[1];
   wire sda      = sda_s_q[1];
   wire scl_rise = scl & ~scl_q;
   wire scl_fall = ~scl & scl_q;
   wire start_ev = scl & scl_q & sda_q & ~sda;
   wire stop_ev  = scl & scl_q & ~sda_q & sda;
   // ---------------------------------------------------------------
   // protocol state
   // ---------------------------------------------------------------
   reg [4:0] state_q;
   reg [3:0] bit_cnt_q;
   reg [7:0] shift_q;
   reg [1:0] byte_no_q;   // bytes received after address
   reg       rw_q;
   reg       ack_q;       // drive data low
   reg       tx_bit_q;    // drive data out when low
   reg [7:0] ptr_q;
   reg [7:0] cmd_q;
   reg [6:0] own_addr_q;
   reg       sample_q;
   reg       wr_en_q;
   reg [7:0] wr_data_q;
   reg [3:0] wr_idx_q;
   wire [7:0] rd_data;
   wire [7:0] n_out;
   wire [7:0] n_rise;
   wire [7:0] n_fall;
   wire [7:0] s_out;
   wire [7:0] s_rise;
   wire [7:0] s_fall;
   // straps pass two flops too; no reset, so they are full by release
   reg  [3:0] sel_m_q;
   reg  [3:0] sel_s_q;
   always @(posedge sys_clk) begin
      sel_m_q <= {addr_sel_hi_pin, addr_sel_lo_pin};
      sel_s_q <= sel_m_q;
   end
   wire [1:0] sel_lo   = sel_s_q[1:0];
   wire [1:0] sel_hi   = sel_s_q[3:2];
   // code 3 counts as high on either select
   wire [1:0] hi_code  = sel_hi[1] ? 2'h2 : sel_hi;
   // strapped address from the two three-level pins
   reg [3:0] addr_base;
   always @* begin
      case (sel_lo)
         `SMX_LVL_LOW:   addr_base = `SMX_ADDR_BASE0;
         `SMX_LVL_FLOAT: addr_base = `SMX_ADDR_BASE1;
         default:        addr_base = `SMX_ADDR_BASE2;
      endcase
   end
   wire [2:0] addr_tail = sel_lo[1] ?
      {1'b0, hi_code} : {1'b1, hi_code};
   // straps are static; the sample strobe is taken a cycle after release
   always @(posedge sys_clk) begin
      if (srst)
         own_addr_q <= 7'h00;
      else if (sample_q)
         own_addr_q <= {addr_base, addr_tail};
   end
   // address match, own strap or alert response
   wire [6:0] rx_addr = shift_q[7:1]; // bit 0 is the direction
   wire addr_hit = (rx_addr == own_addr_q) ||
                   (rx_addr == `SMX_ALERT_ADDR);
   // command pointer maps onto store index, read-only redirected
   wire [3:0] cmd_idx = (cmd_q < 8'h06) ? cmd_q[3:0] : 4'h0;
   wire [3:0] rd_idx  = (ptr_q < 8'h08) ? ptr_q[3:0] : 4'hF;
   // ---------------------------------------------------------------
   // main sequencer
   // ---------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (srst) begin
         state_q   <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q   <= 8'h00;
         byte_no_q <= 2'h0;
         rw_q      <= 1'b0;
         ack_q     <= 1'b0;
         tx_bit_q  <= 1'b1;
         ptr_q     <= `SMX_PTR_RST;
         cmd_q     <= 8'h00;
         sample_q  <= 1'b1;
         wr_en_q   <= 1'b0;
         wr_data_q <= 8'h00;
         wr_idx_q  <= 4'h0;
      end else begin
         sample_q <= 1'b0;
         wr_en_q  <= 1'b0;
         if (start_ev || stop_ev) begin
            // partial bytes are dropped, nothing committed
            state_q   <= start_ev ? ST_RX : ST_IDLE;
            bit_cnt_q <= 4'h0;
            byte_no_q <= 2'h0;
            ack_q     <= 1'b0;
            tx_bit_q  <= 1'b1;
            // a lone command byte then stop is a send-byte
            // the stop's own clock rise has already shifted one bit in
            if (stop_ev && state_q == ST_RX && bit_cnt_q < 4'h2 &&
                byte_no_q == 2'h2) begin
               if (cmd_q == `SMX_CMD_SAMPLE ||
                   cmd_q == `SMX_CMD_SRST)
                  sample_q <= 1'b1;
            end
         end else begin
            case (state_q)
               ST_IDLE: begin
                  bit_cnt_q <= 4'h0;
               end
               ST_RX: begin
                  if (scl_rise) begin
                     shift_q   <= {shift_q[6:0], sda};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end else if (scl_fall && bit_cnt_q == 4'h8) begin
                     // data changes only in clock low phase
                     bit_cnt_q <= 4'h0;
                     if (byte_no_q == 2'h0) begin
                        rw_q <= shift_q[0];
                        if (addr_hit) begin
                           ack_q   <= 1'b1;
                           state_q <= ST_ACK;
                        end else
                           state_q <= ST_IDLE;
                     end else begin
                        ack_q   <= 1'b1;
                        state_q <= ST_ACK;
                        if (byte_no_q == 2'h1) begin
                           cmd_q <= shift_q;
                           // soft reset keeps the pointer it found
                           if (shift_q != `SMX_CMD_SRST)
                              ptr_q <= shift_q;
                        end else
                           wr_data_q <= shift_q;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     ack_q <= 1'b0;
                     if (byte_no_q == 2'h2) begin
                        // commit after the data ack clock falls
                        wr_en_q  <= 1'b1;
                        wr_idx_q <= cmd_idx;
                     end
                     if (byte_no_q != 2'h3)
                        byte_no_q <= byte_no_q + 2'h1;
                     if (byte_no_q == 2'h0 && rw_q) begin
                        state_q   <= ST_TX;
                        shift_q   <= {rd_data[6:0], 1'b1};
                        tx_bit_q  <= rd_data[7];
                        bit_cnt_q <= 4'h1;
                     end else if (byte_no_q == 2'h2)
                        state_q <= ST_IDLE; // no third byte expected
                     else
                        state_q <= ST_RX;
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt_q == 4'h8) begin
                        tx_bit_q <= 1'b1;
                        state_q  <= ST_MACK;
                     end else begin
                        tx_bit_q  <= shift_q[7];
                        shift_q   <= {shift_q[6:0], 1'b1};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                     end
                  end
               end
               ST_MACK: begin
                  // master ack or nack, single byte then wait
                  if (scl_fall)
                     state_q <= ST_IDLE;
               end
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end
   // open drain: enable only to pull low
   assign bus_data_out = 1'b0;
   assign bus_data_oe  = ack_q | ~tx_bit_q;
   // ---------------------------------------------------------------
   // register store and set selection
   // ---------------------------------------------------------------
   smx_regfile u_regs (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .wr_en     (wr_en_q),
      .wr_idx    (wr_idx_q),
      .wr_data   (wr_data_q),
      .rd_idx    (rd_idx),
      .pin_state (lines_s_q),
      .aux_state (aux_status_in),
      .rd_data   (rd_data),
      .n_out     (n_out),
      .n_rise    (n_rise),
      .n_fall    (n_fall),
      .s_out     (s_out),
      .s_rise    (s_rise),
      .s_fall    (s_fall)
   );
   // suspend low picks suspend set, no bus transfer needed
   wire use_norm = sus_s_q[1];
   wire [7:0] out_sel = use_norm ? n_out : s_out;
   assign rise_mask = use_norm ? n_rise : s_rise;
   assign fall_mask = use_norm ? n_fall : s_fall;
   // a zero bit pulls the line low, a one releases it
   assign open_drain_lines_out = 8'h00;
   assign open_drain_lines_oe  = ~out_sel;
endmodule

// [smx_slave_sva.sv]
// concurrent checks on the pins of the expander bus front end
module smx_slave_sva (
   // clock, reset and link pins
   input wire       sys_clk, srst, bus_clk_in, bus_data_in,
   input wire       bus_data_out, bus_data_oe, suspend_select_in,
   // straps and I/O lines
   input wire [1:0] addr_sel_lo_pin, addr_sel_hi_pin,
   input wire [7:0] open_drain_lines_in, aux_status_in,
   input wire [7:0] open_drain_lines_out, open_drain_lines_oe,
   input wire [7:0] rise_mask, fall_mask
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // cycles since suspend moved; a set switch is not a bus write
   logic       susp_q;
   logic [2:0] quiet_q;
   always @(posedge sys_clk) begin
      susp_q <= suspend_select_in;
      if (srst || susp_q != suspend_select_in)
         quiet_q <= 3'h0;
      else if (quiet_q != 3'h7)
         quiet_q <= quiet_q + 3'h1;
   end
   // -----
   // pin relations
   // -----
   chk_reset_masks: assert property (
      $fell(srst) |-> rise_mask == 8'hFF && fall_mask == 8'hFF)
      else $error("masks not all set after reset");
   chk_out_reset: assert property (
      $fell(srst) |-> open_drain_lines_oe == 8'hFF)
      else $error("lines not pulled low after reset");
   chk_oe_clk_low: assert property (
      $changed(bus_data_oe) |-> !bus_clk_in)
      else $error("data drive moved with clock high");
   chk_oe_after_fall: assert property (
      $changed(bus_data_oe) |-> $past(bus_clk_in, 6))
      else $error("data drive moved long after clock fall");
   chk_start_idle: assert property (
      bus_clk_in && $changed(bus_data_in) |-> !bus_data_oe [*6])
      else $error("device drove data at start or stop");
   chk_commit_clk_low: assert property (
      quiet_q == 3'h7 && ($changed(open_drain_lines_oe) ||
      $changed(rise_mask) || $changed(fall_mask))
      |-> !bus_clk_in && $past(bus_clk_in, 8))
      else $error("register update away from ack fall");
   chk_data_low_only: assert property (
      bus_data_out == 1'b0)
      else $error("data pin driven high");
   chk_lines_low_only: assert property (
      open_drain_lines_out == 8'h00)
      else $error("output line driven high");
endmodule
bind smx_slave smx_slave_sva u_sva (.sys_clk, .srst, .bus_clk_in,
   .bus_data_in, .bus_data_out, .bus_data_oe, .suspend_select_in,
   .addr_sel_lo_pin, .addr_sel_hi_pin, .open_drain_lines_in,
   .aux_status_in, .open_drain_lines_out, .open_drain_lines_oe,
   .rise_mask, .fall_mask);

// [smx_host.sv]
// bus master model: clocks the serial link and pulls the data line
module smx_host (
   // system clock, only to keep link edges off its sampling edge
   input  wire  sys_clk,
   // link pins
   input  wire  bus_data_in,
   output logic bus_clk_out,
   output logic pull_low
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int Q = 40; // quarter of the 160 ns link period
   int low_ext = 0;       // extra low time for a slow master
   // -----
   // bit and frame tasks
   // -----
   // link clock stands high and data is released between frames
   initial begin
      bus_clk_out = 1'b1;
      pull_low = 1'b0;
   end
   // one bit slot: data moves only while the clock is low
   task automatic bit_io(input logic b, output logic s);
      pull_low = ~b;
      #(Q + low_ext) bus_clk_out = 1'b1;
      #Q s = bus_data_in;
      #Q bus_clk_out = 1'b0;
      #Q;
   endtask
   task automatic start();
      @(posedge sys_clk);
      #3 pull_low = 1'b0;
      #Q bus_clk_out = 1'b1;
      #Q pull_low = 1'b1;
      #Q bus_clk_out = 1'b0;
      #Q;
   endtask
   task automatic stop();
      pull_low = 1'b1;
      #Q bus_clk_out = 1'b1;
      #Q pull_low = 1'b0;
      #Q;
   endtask
   // msb first, then the ninth clock for the acknowledge
   task automatic put_byte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(v[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic get_byte(input logic ack_it, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         v[i] = s;
      end
      bit_io(~ack_it, s);
   endtask
endmodule

// [tb.sv]
// self-checking bench for the expander bus front end
`include "smx_map.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       sys_clk, srst, susp, scl, m_pull, d_oe, ack;
   logic [1:0] sel_lo, sel_hi;
   logic [7:0] pins, aux, l_oe, r_m, f_m, c, d;
   logic [7:0] regs [0:5];
   logic [6:0] own, nxt;
   int         fail_count, total_checks;
   // data line is pulled up unless a side pulls it low
   wire        sda = ~(m_pull | d_oe);
   smx_slave u_dut (.sys_clk(sys_clk), .srst(srst), .bus_clk_in(scl),
      .bus_data_in(sda), .bus_data_out(), .bus_data_oe(d_oe),
      .addr_sel_lo_pin(sel_lo), .addr_sel_hi_pin(sel_hi),
      .suspend_select_in(susp), .open_drain_lines_in(pins),
      .aux_status_in(aux), .open_drain_lines_out(),
      .open_drain_lines_oe(l_oe), .rise_mask(r_m), .fall_mask(f_m));
   smx_host u_host (.sys_clk(sys_clk), .bus_data_in(sda),
      .bus_clk_out(scl), .pull_low(m_pull));
   // -----
   // checks, expectations and transfers
   // -----
   task automatic chk(input logic [7:0] g, e);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // high and code 3 straps share the low-select's base
   function automatic logic [6:0] strap(input logic [1:0] lo, hi);
      logic [3:0] t;
      t = lo == 2'h0 ? `SMX_ADDR_BASE0 : lo == 2'h1 ? `SMX_ADDR_BASE1
        : `SMX_ADDR_BASE2;
      return {t, (lo > 2'h1 ? 3'h0 : 3'h4) + {1'b0, hi > 2'h1 ? 2'h2 : hi}};
   endfunction
   function automatic logic [7:0] exp_rd(input logic [7:0] k);
      if (k < 8'h06) return regs[k[2:0]];
      return k == 8'h06 ? pins : aux;
   endfunction
   task automatic adr(input logic [6:0] a, input logic rd, ea);
      u_host.put_byte({a, rd}, ack);
      chk({7'h0, ack}, {7'h0, ea});
   endtask
   task automatic head(input logic [7:0] k);
      u_host.start();
      adr(own, 1'b0, 1'b1);
      u_host.put_byte(k, ack);
   endtask
   task automatic wr(input logic [7:0] k, v);
      head(k);
      u_host.put_byte(v, ack);
      u_host.stop();
      regs[k < 8'h06 ? k[2:0] : 3'h0] = v;
      chk({7'h0, ack}, 8'h01);
   endtask
   // repeated start when it follows head, receive-byte otherwise
   task automatic rcv(input logic [7:0] e);
      u_host.start();
      adr(own, 1'b1, 1'b1);
      u_host.get_byte(1'b0, d);
      u_host.stop();
      chk(d, e);
   endtask
   task automatic rd(input logic [7:0] k);
      head(k);
      rcv(exp_rd(k));
   endtask
   task automatic probe(input logic [6:0] a, input logic ea);
      u_host.start();
      adr(a, 1'b0, ea);
      u_host.stop();
   endtask
   task automatic outs();
      int b;
      b = susp ? 0 : 3;
      chk(l_oe, ~regs[b]);
      chk(r_m, regs[b+1]);
      chk(f_m, regs[b+2]);
   endtask
   // system clock and overall watchdog
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (100000) @(posedge sys_clk);
      fail_count++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      {srst, susp, sel_lo, sel_hi, pins, aux} = {2'h3, 20'h0};
      fail_count = 0;
      total_checks = 0;
      regs = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF};
      own = strap(2'h0, 2'h0);
      void'($urandom(32'hfd04f669));
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      outs();
      rcv(8'h00);
      // new straps count only after the sample command
      for (int k = 0; k < 9; k++) begin
         @(posedge sys_clk);
         sel_lo <= 2'(k / 3);
         sel_hi <= 2'(k % 3);
         nxt = strap(2'(k / 3), 2'(k % 3));
         head(`SMX_CMD_SAMPLE);
         u_host.stop();
         if (nxt != own) probe(own, 1'b0);
         own = nxt;
         probe(own, 1'b1);
      end
      probe(`SMX_ALERT_ADDR, 1'b1);
      probe(own ^ 7'h01, 1'b0);
      // random writes with a slow master now and then
      for (int n = 0; n < 10; n++) begin
         c = 8'($urandom_range(5));
         d = n < 2 ? {8{n[0]}} : 8'($urandom);
         u_host.low_ext = 40 * $urandom_range(2);
         wr(c, d);
         rd(c);
         @(posedge sys_clk);
         susp <= 1'($urandom);
         repeat (4) @(posedge sys_clk);
         outs();
      end
      pins <= 8'($urandom);
      aux <= 8'($urandom);
      @(posedge sys_clk);
      wr(`SMX_CMD_RDBK, 8'hA5);
      rd(`SMX_CMD_NOUT);
      rd(`SMX_CMD_RDBK);
      rd(`SMX_CMD_AUX);
      // four data bits cut by stop, then three cut by a repeated start
      d = ~regs[0];
      head(`SMX_CMD_NOUT);
      for (int i = 0; i < 4; i++) u_host.bit_io(d[7-i], ack);
      u_host.stop();
      rd(`SMX_CMD_NOUT);
      d = ~regs[2];
      head(`SMX_CMD_NFALL);
      for (int i = 0; i < 3; i++) u_host.bit_io(d[7-i], ack);
      rd(`SMX_CMD_NFALL);
      rd(`SMX_CMD_SFALL);
      head(`SMX_CMD_SRST);
      u_host.stop();
      rcv(regs[5]);
      tally_and_finish();
   end
endmodule
